// ### verilog/flt_pkg.sv
// package: register map, field positions and timing counts for the fault latch bank
package flt_pkg;
    localparam logic [7:0] FLT_ADDR_GEN_STATUS = 8'h02;
    localparam logic [7:0] FLT_ADDR_RESERVED = 8'h04;
    localparam logic [7:0] FLT_ADDR_FAULT_ONE = 8'h05;
    localparam logic [7:0] FLT_ADDR_FAULT_TWO = 8'h06;
    // reset values
    localparam logic [7:0] FLT_RST_FAULT_ONE = 8'h00;
    localparam logic [7:0] FLT_RST_FAULT_TWO = 8'h00;
    localparam logic [7:0] FLT_RST_RESERVED = 8'h00;
    // fault_flags_one fields
    localparam int FLT_F1_IRQ_RELEASE = 7;
    localparam int FLT_F1_REG_OC_UV = 4;
    localparam int FLT_F1_OVER_TEMP = 3;
    localparam int FLT_F1_SW_OC = 2;
    // fault_flags_two fields
    localparam int FLT_F2_WATCHDOG = 7;
    localparam int FLT_F2_OUT_HICCUP = 6;
    localparam int FLT_F2_IN_UV = 5;
    localparam int FLT_F2_OUT_OV = 4;
    localparam int FLT_F2_LIGHT_LOAD = 3;
    localparam int FLT_F2_IN_OV = 2;
    localparam int FLT_F2_BUS_ERR = 1;
    // general status field that mirrors the interrupt pin
    localparam int FLT_GS_IRQ_PIN = 6;
    // regulator restart delay
    localparam int FLT_REG_RESTART_MS = 100;
    localparam int FLT_CLK_MHZ = 100;
    localparam int FLT_REG_RESTART_CYC = FLT_REG_RESTART_MS * 1000 * FLT_CLK_MHZ;
    localparam int FLT_DLY_W = 24;
    // number of fault sources held in latch bits (all read-to-clear except the watchdog)
    localparam int FLT_NSRC = 9;
    typedef enum logic [1:0] {
        FLT_RS_IDLE = 2'b00,
        FLT_RS_WAIT = 2'b01,
        FLT_RS_DONE = 2'b11
    } flt_rst_e;
endpackage

// ### verilog/flt_latch_bit.sv
// one sticky fault bit with conditional read-to-clear
`timescale 1ns/1ns
module flt_latch_bit
    import flt_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic set_in,
    input wire logic clear_ok_in,
    input wire logic read_in,
    output logic flag_out,
    output logic rise_out
);
    typedef struct packed {
        logic flag;
        logic rise;
    } flt_lb_s;
    flt_lb_s st_reg;
    flt_lb_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rise = set_in & ~st_reg.flag;
        if (set_in) begin
            st_next.flag = 1'b1; // [R21]
        end else if (read_in && clear_ok_in) begin
            st_next.flag = 1'b0; // [R22]
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag_out = st_reg.flag;
    assign rise_out = st_reg.rise;
endmodule

// ### verilog/flt_restart_timer.sv
// restart delay that gates clearing of the regulator fault
`timescale 1ns/1ns
module flt_restart_timer
    import flt_pkg::*;
#(
    parameter int RESTART_CYC = FLT_REG_RESTART_CYC
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    output logic expired_out
);
    typedef struct packed {
        flt_rst_e state;
        logic [FLT_DLY_W-1:0] cnt;
    } flt_rt_s;
    flt_rt_s st_reg;
    flt_rt_s st_next;

    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            FLT_RS_IDLE: begin
                if (start_in) begin
                    st_next.state = FLT_RS_WAIT;
                    st_next.cnt = '0;
                end
            end
            FLT_RS_WAIT: begin
                // a fresh overcurrent restarts the delay
                if (start_in) begin
                    st_next.cnt = '0;
                end else if (st_reg.cnt == FLT_DLY_W'(RESTART_CYC - 1)) begin
                    st_next.state = FLT_RS_DONE;
                end else begin
                    st_next.cnt = st_reg.cnt + 1'b1;
                end
            end
            FLT_RS_DONE: begin
                if (start_in) begin
                    st_next.state = FLT_RS_WAIT;
                    st_next.cnt = '0;
                end
            end
            default: begin
                st_next.state = FLT_RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '{state: FLT_RS_IDLE, cnt: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired_out = (st_reg.state != FLT_RS_WAIT);
endmodule

// ### verilog/flt_fault_regs.sv
// latching fault and status registers with interrupt output
`timescale 1ns/1ns
//
// Operation
// [R1] writing 1 to fault_flags_one bit 7 releases interrupt; bit self-clears
// [R2] interrupt may stay asserted while a fault condition persists after release
// [R3] general status bit 6 reflects the live interrupt pin level
// [R4] regulator overcurrent/undervolt bit 4 latches, read of its register clears
// [R5] regulator fault mask never hides the regulator fault bit
// [R6] regulator fault bit not cleared until restart delay expires
// [R7] over-temperature bit 3 and switch overcurrent bit 2 latch, read clears
// [R8] those two bits are not cleared while their condition persists
// [R9] enabled watchdog expiry sets latching watchdog fault bit 7
// [R10] reading fault_flags_two leaves the watchdog fault bit unchanged
// [R11] watchdog timer restarts on service access or when disabled
// [R12] output hiccup fault bit 6 latches on hiccup from overcurrent
// [R13] hiccup bit held through off period; cleared only by read after exit
// [R14] input undervolt bit 5 latches below programmed threshold
// [R15] input undervolt bit cleared by read only when input above threshold
// [R16] output overvolt bit 4 latches; read clears only below threshold
// [R17] light-load bit 3 latches entering off state; clears by read after exit
// [R18] input overvolt bit 2 latches when powered on; read clears below threshold
// [R19] bus error bit 1 sets on failed command or corrupt data
// [R20] reserved register 0x04 and unused fault bits read zero
// [R21] any fault latching asserts interrupt; set beats simultaneous clear
// [R22] read clears only bits whose clearing condition holds at the read
module flt_fault_regs
    import flt_pkg::*;
#(
    parameter int RESTART_CYC = FLT_REG_RESTART_CYC
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic regulator_overcurrent_undervolt_in,
    input wire logic regulator_oc_event_in,
    input wire logic regulator_fault_mask_in,
    input wire logic over_temperature_in,
    input wire logic switch_overcurrent_in,
    input wire logic watchdog_expired_in,
    input wire logic watchdog_enabled_in,
    input wire logic watchdog_service_in,
    input wire logic output_hiccup_in,
    input wire logic input_below_undervolt_in,
    input wire logic output_overvolt_in,
    input wire logic light_load_off_state_in,
    input wire logic power_on_state_in,
    input wire logic input_overvolt_in,
    input wire logic bus_error_in,
    input wire logic irq_pin_level_in,
    output logic [7:0] reg_rdata_out,
    output logic fault_interrupt_out_n_out,
    output logic fault_interrupt_oe_out,
    output logic watchdog_restart_out,
    output logic irq_pin_status_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] rdata;
        logic irq_n;
        logic wd_restart;
        logic pin_status;
        logic bus_err;
    } flt_top_s;
    flt_top_s st_reg;
    flt_top_s st_next;

    logic rd_one;
    logic rd_two;
    logic irq_release;
    logic reg_delay_done;
    logic [FLT_NSRC-1:0] src_set;
    logic [FLT_NSRC-1:0] src_ok;
    logic [FLT_NSRC-1:0] src_rd;
    logic [FLT_NSRC-1:0] flag;
    logic [FLT_NSRC-1:0] rise;
    logic [7:0] f1_val;
    logic [7:0] f2_val;
    logic [7:0] gs_val;

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    assign rd_one = reg_rd_in && (reg_addr_in == FLT_ADDR_FAULT_ONE);
    assign rd_two = reg_rd_in && (reg_addr_in == FLT_ADDR_FAULT_TWO);
    // release bit is a pulse, never stored, so it always reads back 0
    assign irq_release = reg_wr_in && (reg_addr_in == FLT_ADDR_FAULT_ONE)
        && reg_wdata_in[FLT_F1_IRQ_RELEASE]; // [R1]

    flt_restart_timer #(
        .RESTART_CYC(RESTART_CYC)
    ) u_restart (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .start_in(regulator_oc_event_in),
        .expired_out(reg_delay_done)
    );

    // ------------------------------------------------------------
    // fault sources: index 0..2 in fault_flags_one, 3..8 in two
    // ------------------------------------------------------------
    always_comb begin
        // mask input deliberately unused: status always reports
        src_set[0] = regulator_overcurrent_undervolt_in | regulator_oc_event_in; // [R4] [R5]
        // the timer only leaves idle one edge after the event, so block that edge too
        src_ok[0] = ~regulator_overcurrent_undervolt_in & ~regulator_oc_event_in & reg_delay_done; // [R6]
        src_rd[0] = rd_one; // [R4]
        src_set[1] = over_temperature_in; // [R7]
        src_ok[1] = ~over_temperature_in; // [R8]
        src_rd[1] = rd_one;
        src_set[2] = switch_overcurrent_in; // [R7]
        src_ok[2] = ~switch_overcurrent_in; // [R8]
        src_rd[2] = rd_one;
        src_set[3] = watchdog_enabled_in & watchdog_expired_in; // [R9]
        src_ok[3] = 1'b0; // [R10]
        src_rd[3] = 1'b0; // [R10]
        src_set[4] = output_hiccup_in; // [R12]
        src_ok[4] = ~output_hiccup_in; // [R13]
        src_rd[4] = rd_two;
        src_set[5] = input_below_undervolt_in; // [R14]
        src_ok[5] = ~input_below_undervolt_in; // [R15]
        src_rd[5] = rd_two;
        src_set[6] = output_overvolt_in; // [R16]
        src_ok[6] = ~output_overvolt_in; // [R16]
        src_rd[6] = rd_two;
        src_set[7] = light_load_off_state_in; // [R17]
        src_ok[7] = ~light_load_off_state_in; // [R17]
        src_rd[7] = rd_two;
        src_set[8] = input_overvolt_in & power_on_state_in; // [R18]
        src_ok[8] = ~input_overvolt_in; // [R18]
        src_rd[8] = rd_two;
    end

    genvar gi;
    generate
        for (gi = 0; gi < FLT_NSRC; gi++) begin : g_bit
            flt_latch_bit u_bit (
                .mclk_in(mclk_in),
                .nrst_in(nrst_in),
                .set_in(src_set[gi]),
                .clear_ok_in(src_ok[gi]),
                .read_in(src_rd[gi]),
                .flag_out(flag[gi]),
                .rise_out(rise[gi])
            );
        end
    endgenerate

    // bus error sticks; no clearing condition is defined for it
    logic bus_err_rise;
    assign bus_err_rise = bus_error_in & ~st_reg.bus_err;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        f1_val = FLT_RST_FAULT_ONE; // [R20]
        f1_val[FLT_F1_REG_OC_UV] = flag[0];
        f1_val[FLT_F1_OVER_TEMP] = flag[1];
        f1_val[FLT_F1_SW_OC] = flag[2];
        f2_val = FLT_RST_FAULT_TWO; // [R20]
        f2_val[FLT_F2_WATCHDOG] = flag[3];
        f2_val[FLT_F2_OUT_HICCUP] = flag[4];
        f2_val[FLT_F2_IN_UV] = flag[5];
        f2_val[FLT_F2_OUT_OV] = flag[6];
        f2_val[FLT_F2_LIGHT_LOAD] = flag[7];
        f2_val[FLT_F2_IN_OV] = flag[8];
        f2_val[FLT_F2_BUS_ERR] = st_reg.bus_err;
        gs_val = 8'h00;
        gs_val[FLT_GS_IRQ_PIN] = irq_pin_level_in; // [R3]
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (reg_rd_in) begin
            case (reg_addr_in)
                FLT_ADDR_FAULT_ONE: begin
                    st_next.rdata = f1_val;
                end
                FLT_ADDR_FAULT_TWO: begin
                    st_next.rdata = f2_val;
                end
                FLT_ADDR_GEN_STATUS: begin
                    st_next.rdata = gs_val; // [R3]
                end
                FLT_ADDR_RESERVED: begin
                    st_next.rdata = FLT_RST_RESERVED; // [R20]
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end
        // new latch wins over a release in the same cycle
        if (|rise || bus_err_rise) begin
            st_next.irq_n = 1'b0; // [R21]
        end else if (irq_release) begin
            // live conditions re-assert on their next rising latch only
            st_next.irq_n = 1'b1; // [R1] [R2]
        end
        st_next.wd_restart = watchdog_service_in | ~watchdog_enabled_in; // [R11]
        st_next.pin_status = irq_pin_level_in; // [R3]
        st_next.bus_err = st_reg.bus_err | bus_error_in; // [R19]
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '{
                rdata: 8'h00,
                irq_n: 1'b1,
                wd_restart: 1'b1,
                pin_status: 1'b1,
                bus_err: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out = st_reg.rdata;
    assign fault_interrupt_out_n_out = 1'b0;
    assign fault_interrupt_oe_out = ~st_reg.irq_n;
    assign watchdog_restart_out = st_reg.wd_restart;
    assign irq_pin_status_out = st_reg.pin_status;
endmodule

// ### dv/flt_host.sv
// host model: register reads and writes over the strobe interface
`timescale 1ns/1ns
module flt_host (
    input wire logic mclk_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic [7:0] wdata_out,
    output logic rd_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // idle lines carry the inverse so a stale value never looks live
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = w;
        rd_out = !w;
        @(posedge mclk_in);
        #1;
        q = rdata_in;
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask
endmodule

// ### dv/flt_fault_regs_chk.sv
// checker: port-level assertions for the fault latch bank
`timescale 1ns/1ns
module flt_fault_regs_chk
    import flt_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic over_temperature_in,
    input wire logic watchdog_enabled_in,
    input wire logic watchdog_service_in,
    input wire logic irq_pin_level_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic fault_interrupt_oe_out,
    input wire logic watchdog_restart_out,
    input wire logic irq_pin_status_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    logic rd5;
    logic rd6;
    logic rdr;
    logic relw;
    assign rd5 = reg_rd_in && reg_addr_in == FLT_ADDR_FAULT_ONE;
    assign rd6 = reg_rd_in && reg_addr_in == FLT_ADDR_FAULT_TWO;
    assign rdr = reg_rd_in && reg_addr_in == FLT_ADDR_RESERVED;
    assign relw = reg_wr_in && reg_addr_in == FLT_ADDR_FAULT_ONE && reg_wdata_in[FLT_F1_IRQ_RELEASE];
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_REL_SELF: assert property (rd5 |=> !reg_rdata_out[FLT_F1_IRQ_RELEASE])
        else $error("release bit read back as one");
    AST_REL_DROP: assert property (relw && !over_temperature_in |=> !fault_interrupt_oe_out)
        else $error("interrupt not released by release write");
    AST_PIN_MIRROR: assert property (1'b1 |=> irq_pin_status_out == $past(irq_pin_level_in))
        else $error("pin status does not follow pin level");
    // condition already present one edge earlier, so the flag is surely latched at the read
    AST_OT_HOLD: assert property (rd5 && over_temperature_in && $past(over_temperature_in)
        ##2 rd5 |=> reg_rdata_out[FLT_F1_OVER_TEMP])
        else $error("temperature flag cleared while present");
    AST_OT_CLEAR: assert property ((!over_temperature_in)[*3] ##0 rd5 ##1 !over_temperature_in
        ##1 rd5 && !over_temperature_in |=> !reg_rdata_out[FLT_F1_OVER_TEMP])
        else $error("temperature flag not cleared by read");
    AST_WD_STICKY: assert property (rd6 ##1 reg_rdata_out[FLT_F2_WATCHDOG] ##[1:40] rd6
        |=> reg_rdata_out[FLT_F2_WATCHDOG])
        else $error("watchdog flag cleared by read");
    AST_WD_RESTART: assert property (watchdog_service_in || !watchdog_enabled_in |=> watchdog_restart_out)
        else $error("watchdog restart missing");
    AST_IRQ_RISE: assert property ($rose(over_temperature_in) |-> ##2 fault_interrupt_oe_out)
        else $error("interrupt not raised on latch");
    AST_RSVD_BLK: assert property (rdr |=> reg_rdata_out == FLT_RST_RESERVED)
        else $error("reserved register not zero");
    AST_F1_RSVD: assert property (rd5 |=> reg_rdata_out[6:5] == 2'h0 && reg_rdata_out[1:0] == 2'h0)
        else $error("unused fault bits not zero");
    cover property (relw);
    cover property ($rose(fault_interrupt_oe_out));
    cover property (rd6 ##1 reg_rdata_out[FLT_F2_WATCHDOG]);
    cover property (rd5 ##1 reg_rdata_out[FLT_F1_REG_OC_UV]);
endmodule
bind flt_fault_regs flt_fault_regs_chk chk_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
    .over_temperature_in(over_temperature_in), .watchdog_enabled_in(watchdog_enabled_in),
    .watchdog_service_in(watchdog_service_in), .irq_pin_level_in(irq_pin_level_in), .reg_rdata_out(reg_rdata_out),
    .fault_interrupt_oe_out(fault_interrupt_oe_out), .watchdog_restart_out(watchdog_restart_out),
    .irq_pin_status_out(irq_pin_status_out));

// ### dv/flt_fault_regs_test.sv
// testbench: fault latch bank driven through the host model
`timescale 1ns/1ns
module flt_fault_regs_test;
    import flt_pkg::*;
    localparam int RC = 20;
    localparam logic [7:0] TA [7] = '{8'h05, 8'h05, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06};
    localparam logic [7:0] TM [7] = '{8'h08, 8'h04, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04};
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [6:0] cnd = 7'h00;
    logic reg_uv = 1'b0, reg_ev = 1'b0, reg_mask = 1'b0, pwr = 1'b1, berr = 1'b0;
    logic wd_exp = 1'b0, wd_en = 1'b0, wd_srv = 1'b0;
    logic [7:0] addr, wdata, rdata, q;
    logic wr, rd, oe, wrst, pst, irqd;
    int failures = 0;
    int check_count = 0;
    always #5 mclk_in = ~mclk_in;
    // pull-up on the open-drain interrupt wire
    flt_fault_regs #(.RESTART_CYC(RC)) dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .regulator_overcurrent_undervolt_in(reg_uv),
        .regulator_oc_event_in(reg_ev), .regulator_fault_mask_in(reg_mask), .over_temperature_in(cnd[0]),
        .switch_overcurrent_in(cnd[1]), .watchdog_expired_in(wd_exp), .watchdog_enabled_in(wd_en),
        .watchdog_service_in(wd_srv), .output_hiccup_in(cnd[2]), .input_below_undervolt_in(cnd[3]),
        .output_overvolt_in(cnd[4]), .light_load_off_state_in(cnd[5]), .power_on_state_in(pwr),
        .input_overvolt_in(cnd[6]), .bus_error_in(berr), .irq_pin_level_in(~oe), .reg_rdata_out(rdata),
        .fault_interrupt_out_n_out(irqd), .fault_interrupt_oe_out(oe), .watchdog_restart_out(wrst),
        .irq_pin_status_out(pst));
    flt_host host_u (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
        .rd_out(rd));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host_u.xfer(1'b0, a, 8'h00, q);
        chk("rdata", q, e);
    endtask
    task automatic rel;
        host_u.xfer(1'b1, FLT_ADDR_FAULT_ONE, 8'h80, q);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rdc(FLT_ADDR_FAULT_ONE, FLT_RST_FAULT_ONE);
        rdc(FLT_ADDR_FAULT_TWO, FLT_RST_FAULT_TWO);
        rdc(FLT_ADDR_RESERVED, FLT_RST_RESERVED);
        chk("oe", {7'h00, oe}, 8'h00);
        chk("irq data", {7'h00, irqd}, 8'h00);
        chk("pin out", {7'h00, pst}, 8'h01);
        $display("test reset done");
    endtask
    task automatic t_flags;
        for (int i = 0; i < 7; i++) begin
            cnd[i] = 1'b1;
            cyc(3);
            chk("oe", {7'h00, oe}, 8'h01);
            chk("pin out", {7'h00, pst}, 8'h00);
            rdc(TA[i], TM[i]);
            rdc(TA[i], TM[i]);
            host_u.xfer(1'b0, FLT_ADDR_GEN_STATUS, 8'h00, q);
            chk("pin", {7'h00, q[FLT_GS_IRQ_PIN]}, 8'h00);
            cnd[i] = 1'b0;
            cyc(2);
            rdc(TA[i], TM[i]);
            rdc(TA[i], 8'h00);
            rel();
            cyc(2);
            chk("oe", {7'h00, oe}, 8'h00);
            chk("pin out", {7'h00, pst}, 8'h01);
            host_u.xfer(1'b0, FLT_ADDR_GEN_STATUS, 8'h00, q);
            chk("pin", {7'h00, q[FLT_GS_IRQ_PIN]}, 8'h01);
        end
        $display("test flags done");
    endtask
    task automatic t_inov_off;
        pwr = 1'b0;
        cnd[6] = 1'b1;
        cyc(3);
        rdc(FLT_ADDR_FAULT_TWO, 8'h00);
        cnd[6] = 1'b0;
        pwr = 1'b1;
        $display("test powered-off overvolt done");
    endtask
    // restart count shortened so the delay is seen within a few reads
    task automatic t_reg;
        reg_mask = 1'b1;
        reg_uv = 1'b1;
        reg_ev = 1'b1;
        cyc(1);
        reg_ev = 1'b0;
        cyc(2);
        rdc(FLT_ADDR_FAULT_ONE, 8'h10);
        reg_uv = 1'b0;
        cyc(2);
        rdc(FLT_ADDR_FAULT_ONE, 8'h10);
        cyc(RC);
        rdc(FLT_ADDR_FAULT_ONE, 8'h10);
        rdc(FLT_ADDR_FAULT_ONE, 8'h00);
        rel();
        $display("test regulator done");
    endtask
    task automatic t_wdog;
        chk("restart", {7'h00, wrst}, 8'h01);
        // expiry while disabled must not latch
        wd_exp = 1'b1;
        cyc(1);
        wd_exp = 1'b0;
        cyc(2);
        rdc(FLT_ADDR_FAULT_TWO, 8'h00);
        wd_en = 1'b1;
        wd_exp = 1'b1;
        cyc(1);
        wd_exp = 1'b0;
        cyc(2);
        chk("restart", {7'h00, wrst}, 8'h00);
        rdc(FLT_ADDR_FAULT_TWO, 8'h80);
        rdc(FLT_ADDR_FAULT_TWO, 8'h80);
        wd_srv = 1'b1;
        cyc(2);
        chk("restart", {7'h00, wrst}, 8'h01);
        wd_srv = 1'b0;
        berr = 1'b1;
        cyc(1);
        berr = 1'b0;
        cyc(2);
        rdc(FLT_ADDR_FAULT_TWO, 8'h82);
        rel();
        $display("test watchdog and bus error done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        cyc(12);
        nrst_in = 1'b1;
        cyc(1);
        t_reset();
        t_flags();
        t_inov_off();
        t_reg();
        t_wdog();
        conclude();
    end
    initial begin
        #100000;
        failures++;
        conclude();
    end
endmodule
